// ---- inc/mpg_defines.vh ----
// Constants for the multipurpose pin mode and output gating block
`ifndef MPG_DEFINES_VH
`define MPG_DEFINES_VH
// Register byte offsets on the AXI4-Lite slave
`define MPG_ADDR_CTRL      8'h04
`define MPG_ADDR_PIN_EN    8'h06
`define MPG_ADDR_SD_OE     8'h1C
`define MPG_ADDR_SUSP      8'h1D
`define MPG_ADDR_PLLS      8'h1E
`define MPG_ADDR_OUT_DIV_SEL      8'h20
`define MPG_ADDR_PARK      8'h24
`define MPG_ADDR_STATUS    8'h28
`define MPG_ADDR_LOCKTIME  8'h2C
// Field positions
`define MPG_CTRL_MFC       0
`define MPG_CTRL_PRIM      1
`define MPG_SD_POL         6
`define MPG_SD_FUNC        7
// Widths and counts
`define MPG_NBANK          6
`define MPG_NPIN           6
// Reset values
`define MPG_RST_CTRL       2'h0
`define MPG_RST_PIN_EN     6'h3F
`define MPG_RST_SD_OE      8'h00
`define MPG_RST_BANK       6'h00
`define MPG_RST_PLLS       3'h0
`define MPG_RST_OUT_DIV_SEL       12'h000
`define MPG_RST_PARK       12'h000
`define MPG_RST_LOCKTIME   16'h0010
// Interface select pin levels
`define MPG_IFS_JTAG       2'h0
`define MPG_IFS_MID        2'h1
`define MPG_IFS_I2C        2'h2
// Modes
`define MPG_MODE_MFC1      2'h0
`define MPG_MODE_MFC2      2'h1
`define MPG_MODE_I2C       2'h2
`define MPG_MODE_JTAG      2'h3
// Response codes
`define MPG_RESP_OK        2'h0
`define MPG_RESP_SLVERR    2'h2
`endif

// ---- src/mpg_pin_mux.v ----
// Multipurpose pin mode select, configuration select and output gating
//
// How it works
// - Mode 2: pin pairs index PLL0, PLL1, PLL2
// - Per-configuration divider select picks post-divider set
// - I2C mode maps data, clock, suspend, clock select
// - JTAG mode maps TAP pins and TDO
// - Manual modes drive lock and clock loss outputs
// - Mode 2 uses primary reference, bit switches
// - Power-up latches pins 0..4, pin 5 low
// - Programming mode keeps latched configuration
// - Manual modes follow select pins continuously
// - Pin enable masks inputs to low
// - Masked serial pins still work; suspend, select die
// - Polarity bit sets shutdown pin active level
// - Function bit: shutdown overrides, else output enable
// - Output enable disables masked banks only
// - Park mode: tristate, low or high
// - Shutdown tristates, forces manual, refuses programming
// - Suspend powers down flagged banks
// - PLL suspend wins, takes its banks too
// - Relock wait after PLL suspend only
// - Mode 1: three pins pick eight PLL0 configs
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "mpg_defines.vh"

module mpg_pin_mux (
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Board pins
  input  wire [5:0]  cfg_pin,
  input  wire [1:0]  if_sel_level,
  input  wire        sd_oe_pin,
  // Status sources from the clock core
  input  wire        lock_lost,
  input  wire        ref_clock_lost,
  input  wire        jtag_tdo,
  input  wire        jtag_tdo_en,
  input  wire [2:0]  pll_locked,
  // Pin outputs
  output reg         status_out0,
  output reg         status_out0_oe,
  output reg         status_out1,
  // Decoded functions toward the core
  output reg  [1:0]  mode,
  output reg         prog_allowed,
  output reg         serial_data_pin,
  output reg         serial_clk,
  output reg         jtag_tms,
  output reg         jtag_trst,
  output reg         suspend_act,
  output reg         clk_select,
  output reg  [2:0]  pll0_cfg,
  output reg  [1:0]  pll1_cfg,
  output reg  [1:0]  pll2_cfg,
  output reg  [2:0]  out_div_sel,
  output reg  [2:0]  pll_power_down,
  output reg  [2:0]  pll_out_valid,
  output reg  [5:0]  bank_enable,
  output reg  [5:0]  bank_drive,
  output reg  [5:0]  bank_level,
  output reg         ref_osc_power_down
);

  // Configuration registers
  reg  [1:0]  ctrl_q;
  reg  [5:0]  pin_en_q;
  reg  [7:0]  sd_oe_q;
  reg  [5:0]  susp_q;
  reg  [2:0]  plls_q;
  reg  [11:0] out_div_sel_q;
  reg  [11:0] park_q;
  reg  [15:0] locktime_q;

  // Three-stage pin synchronisers, all bits in one loop
  localparam NSYNC = 10;
  wire [NSYNC-1:0] raw_in = {if_sel_level, sd_oe_pin, cfg_pin, 1'b0};
  reg  [NSYNC-1:0] s1_q;
  reg  [NSYNC-1:0] s2_q;
  reg  [NSYNC-1:0] s3_q;
  reg  [NSYNC-1:0] clean_q;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      // Change accepted once stages two and three agree
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_q[gi]    <= 1'b0;
          s2_q[gi]    <= 1'b0;
          s3_q[gi]    <= 1'b0;
          clean_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            clean_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  wire [5:0] pin_s   = clean_q[6:1];
  wire       sd_s    = clean_q[7];
  wire [1:0] ifsel_s = clean_q[9:8];

  // Shutdown decode
  wire sd_asserted = sd_s ^ sd_oe_q[`MPG_SD_POL];
  wire shutdown    = sd_asserted & sd_oe_q[`MPG_SD_FUNC];
  wire oe_pin_act  = sd_asserted & ~sd_oe_q[`MPG_SD_FUNC];

  // Effective interface select; shutdown forces the mid level
  wire [1:0] ifsel_eff = shutdown ? `MPG_IFS_MID : ifsel_s;
  wire       prog_mode = (ifsel_eff != `MPG_IFS_MID);
  wire [5:0] pin_m     = pin_s & pin_en_q;

  // Power-up latch: catch pins 0..4 at the first settled cycle
  reg  [2:0] boot_cnt_q;
  reg        latched_q;
  reg  [4:0] boot_pins_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      boot_cnt_q  <= 3'h0;
      latched_q   <= 1'b0;
      boot_pins_q <= 5'h00;
    end
    else if (!latched_q)
    begin
      boot_cnt_q <= boot_cnt_q + 3'h1;
      if (boot_cnt_q == 3'h5)
      begin
        latched_q   <= 1'b1;
        boot_pins_q <= pin_s[4:0];
      end
    end
  end

  // Held selection while programming; taken at power-up or on entry
  reg [4:0] held_q;
  reg       prog_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      held_q <= 5'h00;
      prog_q <= 1'b0;
    end
    else
    begin
      prog_q <= prog_mode;
      if (!latched_q && boot_cnt_q == 3'h5)
        held_q <= pin_s[4:0];
      else if (prog_mode && !prog_q)
        held_q <= pin_m[4:0];
    end
  end

  // Mode and configuration select decode
  reg [5:0] sel;
  always @*
  begin
    if (!latched_q)
      mode = `MPG_MODE_MFC2;
    else if (ifsel_eff == `MPG_IFS_I2C)
      mode = `MPG_MODE_I2C;
    else if (ifsel_eff == `MPG_IFS_JTAG)
      mode = `MPG_MODE_JTAG;
    else if (ctrl_q[`MPG_CTRL_MFC])
      mode = `MPG_MODE_MFC1;
    else
      mode = `MPG_MODE_MFC2;
    if (!latched_q)
      sel = {1'b0, boot_pins_q};
    else if (prog_mode)
      sel = {1'b0, held_q};
    else
      sel = pin_m;
    prog_allowed = latched_q & prog_mode & ~shutdown;
    pll0_cfg = 3'h0;
    pll1_cfg = 2'h0;
    pll2_cfg = 2'h0;
    if (mode == `MPG_MODE_MFC1)
      pll0_cfg = sel[2:0];
    else
    begin
      pll0_cfg = {1'b0, sel[1:0]};
      pll1_cfg = sel[3:2];
      pll2_cfg = sel[5:4];
    end
    // Serial pins stay live even when masked
    serial_data_pin = 1'b0;
    serial_clk      = 1'b0;
    jtag_tms        = 1'b0;
    jtag_trst       = 1'b0;
    case (mode)
      `MPG_MODE_I2C:
      begin
        serial_data_pin = pin_s[0];
        serial_clk      = pin_s[1];
      end
      `MPG_MODE_JTAG:
      begin
        serial_data_pin = pin_s[0];
        serial_clk      = pin_s[1];
        jtag_tms        = pin_s[2];
        jtag_trst       = pin_s[4];
      end
      default:
        serial_clk = 1'b0;
    endcase
    // Suspend on pin 3 except in mode 2; masking kills it
    suspend_act = (mode != `MPG_MODE_MFC2) & pin_m[3];
    // Clock select on pin 5, mode 2 uses the primary select bit
    if (mode == `MPG_MODE_MFC2)
      clk_select = ctrl_q[`MPG_CTRL_PRIM];
    else
      clk_select = pin_m[5];
  end

  // Output divider select from the active configuration
  wire [3:0] cfg0_4 = {2'h0, pll0_cfg[1:0]};
  always @*
  begin
    out_div_sel[0] = out_div_sel_q[cfg0_4];
    out_div_sel[1] = out_div_sel_q[4'h4 + {2'h0, pll1_cfg}];
    out_div_sel[2] = out_div_sel_q[4'h8 + {2'h0, pll2_cfg}];
    if (mode == `MPG_MODE_MFC1 && pll0_cfg[2])
      out_div_sel[0] = out_div_sel_q[{pll0_cfg[1], ~pll0_cfg[1], 1'b1, pll0_cfg[0]}];
  end

  // Status pins by mode
  always @*
  begin
    status_out0    = lock_lost;
    status_out0_oe = 1'b1;
    status_out1    = ref_clock_lost;
    if (mode == `MPG_MODE_JTAG)
    begin
      status_out0    = jtag_tdo;
      status_out0_oe = jtag_tdo_en;
    end
  end

  // PLL suspend and relock wait
  reg [15:0] relock_q [0:2];
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp = gp + 1)
    begin : g_pll
      always @(posedge aclk)
      begin
        if (!aresetn)
          relock_q[gp] <= 16'h0000;
        else if (pll_power_down[gp])
          relock_q[gp] <= locktime_q;
        else if (relock_q[gp] != 16'h0000 && pll_locked[gp])
          relock_q[gp] <= relock_q[gp] - 16'h0001;
      end
      always @*
      begin
        pll_power_down[gp] = suspend_act & plls_q[gp] & ~shutdown;
        pll_out_valid[gp]  = ~pll_power_down[gp] & (relock_q[gp] == 16'h0000);
      end
    end
  endgenerate

  // Bank gating; banks 0,1 on PLL0, 2,3 on PLL1, 4,5 on PLL2
  genvar gb;
  generate
    for (gb = 0; gb < `MPG_NBANK; gb = gb + 1)
    begin : g_bank
      wire pll_off = pll_power_down[gb/2];
      wire susp    = ~shutdown & suspend_act & susp_q[gb];
      wire oe_off  = oe_pin_act & sd_oe_q[gb];
      always @*
      begin
        bank_enable[gb] = ~(shutdown | pll_off | susp | oe_off);
        bank_drive[gb]  = 1'b1;
        bank_level[gb]  = 1'b0;
        if (shutdown || pll_off || susp)
          bank_drive[gb] = 1'b0;
        else if (oe_off)
        begin
          bank_drive[gb] = park_q[2*gb+1];
          bank_level[gb] = park_q[2*gb];
        end
      end
    end
  endgenerate

  always @*
    ref_osc_power_down = shutdown;

  // AXI4-Lite write path: address and data taken in either order
  reg        aw_hold_q;
  reg [7:0]  aw_addr_q;
  reg        w_hold_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  wire [7:0]  wa = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wd = w_hold_q ? w_data_q : s_axi_wdata;
  wire [3:0]  ws = w_hold_q ? w_strb_q : s_axi_wstrb;
  wire aw_ok = aw_hold_q | (s_axi_awvalid & s_axi_awready);
  wire w_ok  = w_hold_q | (s_axi_wvalid & s_axi_wready);
  wire do_wr = aw_ok & w_ok & ~s_axi_bvalid;
  wire wr_hit = (wa == `MPG_ADDR_CTRL) | (wa == `MPG_ADDR_PIN_EN) | (wa == `MPG_ADDR_SD_OE)
              | (wa == `MPG_ADDR_SUSP) | (wa == `MPG_ADDR_PLLS) | (wa == `MPG_ADDR_OUT_DIV_SEL)
              | (wa == `MPG_ADDR_PARK) | (wa == `MPG_ADDR_LOCKTIME);

  // Register writes and write response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q    <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_hold_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MPG_RESP_OK;
      ctrl_q       <= `MPG_RST_CTRL;
      pin_en_q     <= `MPG_RST_PIN_EN;
      sd_oe_q      <= `MPG_RST_SD_OE;
      susp_q       <= `MPG_RST_BANK;
      plls_q       <= `MPG_RST_PLLS;
      out_div_sel_q       <= `MPG_RST_OUT_DIV_SEL;
      park_q       <= `MPG_RST_PARK;
      locktime_q   <= `MPG_RST_LOCKTIME;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !w_ok)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !aw_ok)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `MPG_RESP_OK : `MPG_RESP_SLVERR;
        if (ws[0])
        begin
          if (wa == `MPG_ADDR_CTRL)     ctrl_q   <= wd[1:0];
          if (wa == `MPG_ADDR_PIN_EN)   pin_en_q <= wd[5:0];
          if (wa == `MPG_ADDR_SD_OE)    sd_oe_q  <= wd[7:0];
          if (wa == `MPG_ADDR_SUSP)     susp_q   <= wd[5:0];
          if (wa == `MPG_ADDR_PLLS)     plls_q   <= wd[2:0];
          if (wa == `MPG_ADDR_OUT_DIV_SEL)     out_div_sel_q[7:0] <= wd[7:0];
          if (wa == `MPG_ADDR_PARK)     park_q[7:0] <= wd[7:0];
          if (wa == `MPG_ADDR_LOCKTIME) locktime_q[7:0] <= wd[7:0];
        end
        if (ws[1])
        begin
          if (wa == `MPG_ADDR_OUT_DIV_SEL)     out_div_sel_q[11:8] <= wd[11:8];
          if (wa == `MPG_ADDR_PARK)     park_q[11:8] <= wd[11:8];
          if (wa == `MPG_ADDR_LOCKTIME) locktime_q[15:8] <= wd[15:8];
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `MPG_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `MPG_RESP_OK;
      case (s_axi_araddr)
        `MPG_ADDR_CTRL:     s_axi_rdata <= {30'h0, ctrl_q};
        `MPG_ADDR_PIN_EN:   s_axi_rdata <= {26'h0, pin_en_q};
        `MPG_ADDR_SD_OE:    s_axi_rdata <= {24'h0, sd_oe_q};
        `MPG_ADDR_SUSP:     s_axi_rdata <= {26'h0, susp_q};
        `MPG_ADDR_PLLS:     s_axi_rdata <= {29'h0, plls_q};
        `MPG_ADDR_OUT_DIV_SEL:     s_axi_rdata <= {20'h0, out_div_sel_q};
        `MPG_ADDR_PARK:     s_axi_rdata <= {20'h0, park_q};
        `MPG_ADDR_LOCKTIME: s_axi_rdata <= {16'h0, locktime_q};
        `MPG_ADDR_STATUS:   s_axi_rdata <= {10'h000, pll_out_valid, bank_enable, shutdown,
                                            prog_allowed, mode, 2'h0, pll0_cfg, pll1_cfg, pll2_cfg};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `MPG_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // mpg_pin_mux

// ---- tb/mpg_pin_mux_asserts.sv ----
// Port checker for the pin mux block
`timescale 1ns/1ns
module mpg_chk (
  input wire       aclk,
  input wire       aresetn,
  input wire [5:0] cfg_pin,
  input wire       lock_lost,
  input wire       ref_clock_lost,
  input wire       jtag_tdo,
  input wire       status_out0,
  input wire       status_out1,
  input wire [1:0] mode,
  input wire       prog_allowed,
  input wire       suspend_act,
  input wire [2:0] pll0_cfg,
  input wire [1:0] pll1_cfg,
  input wire [1:0] pll2_cfg,
  input wire [2:0] pll_power_down,
  input wire [2:0] pll_out_valid,
  input wire [5:0] bank_enable,
  input wire [5:0] bank_drive,
  input wire       ref_osc_power_down
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pins quiet, then a single change
  sequence pins_quiet;
    $stable(cfg_pin) [*4];
  endsequence
  sequence pin_step;
    pins_quiet ##1 $changed(cfg_pin);
  endsequence
  a_sync_delay: assert property (pin_step |=> $stable({pll0_cfg, pll1_cfg, pll2_cfg}) [*2])
    else $error("select followed pins too soon");
  a_clk_loss: assert property (status_out1 == ref_clock_lost)
    else $error("clock loss output wrong");
  a_tdo_jtag: assert property (mode == 2'h3 |-> status_out0 == jtag_tdo)
    else $error("tdo not on status pin");
  a_lock_loss: assert property (mode != 2'h3 |-> status_out0 == lock_lost)
    else $error("lock loss not on status pin");
  a_shut_down: assert property (ref_osc_power_down |-> bank_drive == 6'h00 && mode == 2'h1 && !prog_allowed)
    else $error("shutdown state wrong");
  a_prog_mode: assert property (prog_allowed |-> mode[1])
    else $error("programming outside serial modes");
  a_all_pll: assert property (mode == 2'h1 |-> !suspend_act)
    else $error("suspend active in all pll mode");
  a_pll_banks: assert property (pll_power_down[0] |-> bank_enable[1:0] == 2'h0 && !pll_out_valid[0])
    else $error("pll banks alive in suspend");
  a_relock_wait: assert property ($fell(pll_power_down[0]) |-> (!pll_out_valid[0]) [*8])
    else $error("pll valid without relock");
endmodule // mpg_chk

bind mpg_pin_mux mpg_chk i_mpg_chk (.aclk, .aresetn, .cfg_pin, .lock_lost, .ref_clock_lost, .jtag_tdo,
  .status_out0, .status_out1, .mode, .prog_allowed, .suspend_act, .pll0_cfg, .pll1_cfg, .pll2_cfg,
  .pll_power_down, .pll_out_valid, .bank_enable, .bank_drive, .ref_osc_power_down);

// ---- tb/mpg_core_model.sv ----
// Behavioural clock core facing the pin mux
`timescale 1ns/1ns
module mpg_core_model (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [2:0] pll_power_down,
  output reg  [2:0] pll_locked,
  output wire       lock_lost,
  output wire       ref_clock_lost,
  output wire       jtag_tdo,
  output wire       jtag_tdo_en
);
  reg [3:0] cnt_q;
  // Status pattern that moves every cycle
  always @(posedge aclk)
  begin
    cnt_q <= aresetn ? cnt_q + 4'h1 : 4'h0;
  end
  assign lock_lost      = cnt_q[0];
  assign ref_clock_lost = cnt_q[1];
  assign jtag_tdo       = cnt_q[2] ^ cnt_q[0];
  assign jtag_tdo_en    = cnt_q[3];
  // Powered-down PLL loses lock, regains it some cycles later
  always @(posedge aclk)
  begin
    pll_locked <= aresetn ? ~pll_power_down & (pll_locked | {3{cnt_q[2]}}) : 3'h7;
  end
endmodule // mpg_core_model

// ---- tb/tb.sv ----
// Self-checking bench for the pin mux block
`timescale 1ns/1ns
`include "mpg_defines.vh"
module tb;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awa = 8'h00;
  reg  [7:0]  ara = 8'h00;
  reg  [31:0] wd = 32'h0;
  reg         awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  reg  [5:0]  cfg_pin = 6'h00;
  reg  [1:0]  if_sel_level = `MPG_IFS_MID;
  reg         sd_oe_pin = 1'b0;
  wire        awr, wrd, bv, arr, rv, lock_lost, ref_clock_lost, jtag_tdo, jtag_tdo_en, status_out0;
  wire        status_out1, prog_allowed, serial_data_pin, serial_clk, jtag_tms, jtag_trst;
  wire        suspend_act, clk_select, ref_osc_power_down;
  wire [1:0]  bresp, rresp, mode, pll1_cfg, pll2_cfg;
  wire [31:0] rdata;
  wire [2:0]  pll_locked, pll0_cfg, out_div_sel, pll_power_down, pll_out_valid;
  wire [5:0]  bank_enable, bank_drive, bank_level;
  integer     fails = 0;
  integer     num_checks = 0;
  integer     i, n;
  reg  [31:0] rd;
  reg  [1:0]  rs;
  reg  [5:0]  d;
  reg  [31:0] rnd;

  mpg_pin_mux i_mpg_pin_mux (
    .aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .cfg_pin, .if_sel_level, .sd_oe_pin,
    .lock_lost, .ref_clock_lost, .jtag_tdo, .jtag_tdo_en, .pll_locked, .status_out0, .status_out0_oe(),
    .status_out1, .mode, .prog_allowed, .serial_data_pin, .serial_clk, .jtag_tms, .jtag_trst, .suspend_act,
    .clk_select, .pll0_cfg, .pll1_cfg, .pll2_cfg, .out_div_sel, .pll_power_down, .pll_out_valid,
    .bank_enable, .bank_drive, .bank_level, .ref_osc_power_down);

  mpg_core_model i_mpg_core_model (.aclk, .aresetn, .pll_power_down, .pll_locked, .lock_lost,
    .ref_clock_lost, .jtag_tdo, .jtag_tdo_en);

  // 50 ns clock
  always #25 aclk = ~aclk;

  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask

  task tick(input integer k);
    repeat (k) @(posedge aclk);
  endtask

  // Bounded wait that ends the run when exhausted
  task limit;
    if (n >= 40)
    begin
      fails = fails + 1;
      end_of_test;
    end
  endtask

  task wr(input [7:0] a, input [31:0] v);
  begin
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n = n + 1;
      if (awr)
        awv <= 1'b0;
      if (wrd)
        wv <= 1'b0;
    end while (!bv && n < 40);
    limit;
  end
  endtask

  task rd_reg(input [7:0] a);
  begin
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n = n + 1;
      if (arr)
        arv <= 1'b0;
      if (rv)
      begin
        rd = rdata;
        rs = rresp;
      end
    end while (!rv && n < 40);
    limit;
  end
  endtask

  // Selects and divider choice for the manual modes
  function [9:0] exp_cfg(input m, input [5:0] p, input [11:0] od);
    reg [2:0] c;
    begin
      c = m ? p[2:0] : {1'b0, p[1:0]};
      exp_cfg[9:3] = m ? {c, 4'h0} : {c, p[3:2], p[5:4]};
      exp_cfg[0] = od[c < 4 ? c : c + (c < 6 ? 2 : 4)];
      exp_cfg[1] = od[m ? 4 : 4 + p[3:2]];
      exp_cfg[2] = od[m ? 8 : 8 + p[5:4]];
    end
  endfunction

  // Enable, drive and parked level of the banks
  function [17:0] oe_exp(input [5:0] dm, input [11:0] pk);
    integer b;
    begin
      for (b = 0; b < 6; b = b + 1)
      begin
        oe_exp[12 + b] = !dm[b];
        oe_exp[6 + b] = !dm[b] || pk[2 * b + 1];
        oe_exp[b] = dm[b] && pk[2 * b];
      end
    end
  endfunction

  // Main sequence
  initial
  begin
    rd = $urandom(56);
    tick(12);
    aresetn <= 1'b1;
    tick(10);
    chk("boot select", {2'h1, 7'h00}, {mode, pll0_cfg, pll1_cfg, pll2_cfg});
    rd_reg(`MPG_ADDR_PIN_EN);
    chk("pin enable", 32'h3F, rd);
    rd_reg(8'h30);
    chk("unmapped resp", {30'h0, `MPG_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
    for (i = 0; i < 12; i = i + 1)
    begin
      rd = $urandom;
      d = (i < 4) ? 6'h3F : rd[5:0];
      wr(`MPG_ADDR_CTRL, {31'h0, i[0]});
      wr(`MPG_ADDR_PIN_EN, {26'h0, d});
      wr(`MPG_ADDR_OUT_DIV_SEL, {20'h0, rd[23:12]});
      cfg_pin <= (i == 2) ? 6'h3F : rd[11:6];
      tick(8);
      chk("cfg select", exp_cfg(i[0], cfg_pin & d, rd[23:12]), {pll0_cfg, pll1_cfg, pll2_cfg, out_div_sel});
    end
    wr(`MPG_ADDR_CTRL, 32'h0);
    wr(`MPG_ADDR_PIN_EN, 32'h3F);
    cfg_pin <= 6'h3F;
    tick(8);
    if_sel_level <= `MPG_IFS_I2C;
    tick(8);
    for (i = 0; i < 6; i = i + 1)
    begin
      rd = $urandom;
      if_sel_level <= (i < 3) ? `MPG_IFS_I2C : `MPG_IFS_JTAG;
      cfg_pin <= rd[5:0];
      tick(8);
      chk("serial pins", {(i < 3) ? `MPG_MODE_I2C : `MPG_MODE_JTAG, rd[5], rd[3], rd[1:0], 7'h3D},
        {mode, clk_select, suspend_act, serial_clk, serial_data_pin, pll0_cfg, pll1_cfg, pll2_cfg});
      if (i >= 3)
        chk("tap pins", {rd[2], rd[4]}, {jtag_tms, jtag_trst});
    end
    if_sel_level <= `MPG_IFS_I2C;
    wr(`MPG_ADDR_PIN_EN, 32'h0);
    cfg_pin <= 6'h2B;
    tick(8);
    chk("masked pins", 4'hC, {serial_data_pin, serial_clk, suspend_act, clk_select});
    wr(`MPG_ADDR_PIN_EN, 32'h3F);
    wr(`MPG_ADDR_SUSP, 32'h0C);
    wr(`MPG_ADDR_PLLS, 32'h1);
    cfg_pin <= 6'h08;
    tick(8);
    chk("suspend", {6'h30, 3'h1}, {bank_enable, pll_power_down});
    wr(`MPG_ADDR_PIN_EN, 32'h37);
    chk("relock wait", 1'b0, pll_out_valid[0]);
    tick(40);
    chk("resumed", {6'h3F, 3'h0, 3'h7}, {bank_enable, pll_power_down, pll_out_valid});
    wr(`MPG_ADDR_PIN_EN, 32'h3F);
    cfg_pin <= 6'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      rnd = $urandom;
      d = i[1] ? 6'h00 : rnd[5:0];
      wr(`MPG_ADDR_SD_OE, {24'h0, 1'b0, i[0], rnd[5:0]});
      wr(`MPG_ADDR_PARK, {20'h0, rnd[17:6]});
      rd_reg(`MPG_ADDR_SD_OE);
      chk("oe reg", {24'h0, 1'b0, i[0], rnd[5:0]}, rd);
      sd_oe_pin <= ~i[0] ^ i[1];
      tick(8);
      chk("banks", oe_exp(d, rnd[17:6]), {bank_enable, bank_drive, bank_level & d});
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(`MPG_ADDR_SD_OE, {24'h0, 1'b1, i > 0, 6'h00});
      sd_oe_pin <= (i != 1);
      tick(8);
      chk("shutdown", (i < 2) ? {`MPG_MODE_MFC2, 8'h01} : {`MPG_MODE_I2C, 1'b1, 6'h3F, 1'b0},
        {mode, prog_allowed, bank_drive, ref_osc_power_down});
    end
    end_of_test;
  end
endmodule // tb
